// *** logic/ppmc_pkg.sv ***
// Operation
// - two same-position bits select each pin mode
// - 00 quasi, 01 push-pull, 10 input, 11 drain
// - bits 7..5 pick schmitt or ttl inputs
// - bit 4 routes clock to crystal pin
// - bit 3 toggles p0.7 on timer1 overflow
// - bit 2 toggles p1.2 on timer0 overflow
package ppmc_pkg;

  // ----------------------------------------
  // pin modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    ppmc_mode_quasi,
    ppmc_mode_push_pull,
    ppmc_mode_input_only,
    ppmc_mode_open_drain
  } ppmc_mode_type;

  // ----------------------------------------
  // bus shape
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [7:0] IDX_PORT0_MODE_LOW = 8'hb1;
  localparam logic [7:0] IDX_PORT0_MODE_HIGH = 8'hb2;
  localparam logic [7:0] IDX_PORT1_MODE_LOW = 8'hb3;
  localparam logic [7:0] IDX_PORT1_MODE_HIGH = 8'hb4;
  localparam logic [7:0] IDX_PORT2_MODE_LOW_MISC = 8'hb5;
  localparam logic [7:0] IDX_PORT2_MODE_HIGH = 8'hb6;

  // ----------------------------------------
  // field positions in port2_mode_low_misc
  // ----------------------------------------
  localparam int BIT_PORT2_SCHMITT = 7;
  localparam int BIT_PORT1_SCHMITT = 6;
  localparam int BIT_PORT0_SCHMITT = 5;
  localparam int BIT_CLOCK_OUT_EN = 4;
  localparam int BIT_TIMER1_TOGGLE_EN = 3;
  localparam int BIT_TIMER0_TOGGLE_EN = 2;
  localparam int PORT2_PINS = 2;

  // ----------------------------------------
  // implemented bits and reset values
  // ----------------------------------------
  localparam logic [7:0] PORT1_IMPL_MASK = 8'hdf;
  localparam logic [7:0] PORT2_HIGH_IMPL_MASK = 8'h03;
  localparam logic [7:0] RST_MODE_REG = 8'h00;
  localparam logic RST_TOGGLE_LEVEL = 1'b0;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction

  function automatic ppmc_mode_type mode_of(input logic m1, input logic m2);
    case ({m1, m2})
      2'h0: mode_of = ppmc_mode_quasi;
      2'h1: mode_of = ppmc_mode_push_pull;
      2'h2: mode_of = ppmc_mode_input_only;
      default: mode_of = ppmc_mode_open_drain;
    endcase
  endfunction

endpackage

// *** logic/ppmc_mode_decode.sv ***
`timescale 1ns/1ps
module ppmc_mode_decode #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic [WIDTH-1:0] mode_low,
  input wire logic [WIDTH-1:0] mode_high,
  output logic [2*WIDTH-1:0] pin_mode
);

  // ----------------------------------------
  // per-pin decode
  // ----------------------------------------
  // bit pairing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode <= '0;
    end else if (pclken) begin
      for (int i = 0; i < WIDTH; i++) begin
        pin_mode[2*i +: 2] <= ppmc_pkg::mode_of(mode_low[i], mode_high[i]);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_open_drain;
    @(posedge pclk) disable iff (!presetn)
    (pclken && mode_low[0] && mode_high[0])
      |=> pin_mode[1:0] == ppmc_pkg::ppmc_mode_open_drain;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain decode wrong");

  property p_input_only;
    @(posedge pclk) disable iff (!presetn)
    (pclken && mode_low[WIDTH-1] && !mode_high[WIDTH-1])
      |=> pin_mode[2*WIDTH-1 -: 2] == ppmc_pkg::ppmc_mode_input_only;
  endproperty
  a_input_only: assert property (p_input_only) else $error("input-only decode wrong");

endmodule

// *** logic/ppmc_toggle.sv ***
`timescale 1ns/1ps
module ppmc_toggle (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic enable,
  input wire logic overflow,
  output logic level
);

  // ----------------------------------------
  // toggle on overflow
  // ----------------------------------------
  // level holds while disabled so re-enabling resumes without a glitch
  // overflow toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= ppmc_pkg::RST_TOGGLE_LEVEL;
    end else if (pclken && enable && overflow) begin
      level <= ~level;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
    (pclken && enable && overflow) |=> level != $past(level);
  endproperty
  a_toggle: assert property (p_toggle) else $error("overflow did not toggle");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !(pclken && enable && overflow) |=> $stable(level);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved without overflow");

endmodule

// *** logic/ppmc_top.sv ***
`timescale 1ns/1ps
module ppmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [ppmc_pkg::DATA_W-1:0] pwdata,
  output logic [ppmc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  output logic [15:0] port0_pin_mode,
  output logic [15:0] port1_pin_mode,
  output logic [3:0] port2_pin_mode,
  output logic port2_schmitt_select,
  output logic port1_schmitt_select,
  output logic port0_schmitt_select,
  output logic clock_out_enable,
  output logic timer1_toggle_out_enable,
  output logic timer0_toggle_out_enable,
  output logic port0_pin7_toggle_level,
  output logic port1_pin2_toggle_level
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] port0_mode_low;
  logic [7:0] port0_mode_high;
  logic [7:0] port1_mode_low;
  logic [7:0] port1_mode_high;
  logic [7:0] port2_mode_low_misc;
  logic [1:0] port2_mode_high;

  logic [7:0] next_rdata;
  logic next_hit;
  logic wr_access;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b1;
    case (paddr)
      ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT0_MODE_LOW): begin
        next_rdata = port0_mode_low;
      end
      ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT0_MODE_HIGH): begin
        next_rdata = port0_mode_high;
      end
      ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT1_MODE_LOW): begin
        next_rdata = port1_mode_low & ppmc_pkg::PORT1_IMPL_MASK;
      end
      ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT1_MODE_HIGH): begin
        next_rdata = port1_mode_high & ppmc_pkg::PORT1_IMPL_MASK;
      end
      ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC): begin
        next_rdata = port2_mode_low_misc;
      end
      ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_HIGH): begin
        next_rdata = {6'h00, port2_mode_high};
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  // answer is loaded at the setup edge, so every access has exactly one
  // access cycle and all bus outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (pclken) begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (pclken && psel && !penable) begin
      prdata <= {24'h000000, next_rdata};
      pslverr <= !next_hit;
    end
  end

  // writes land only on the completing edge and never on an error
  assign wr_access = pclken && psel && penable && pready && pwrite && !pslverr;

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  // port0 pairs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_mode_low <= ppmc_pkg::RST_MODE_REG;
      port0_mode_high <= ppmc_pkg::RST_MODE_REG;
    end else if (wr_access) begin
      if (paddr == ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT0_MODE_LOW)) begin
        port0_mode_low <= pwdata[7:0];
      end
      if (paddr == ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT0_MODE_HIGH)) begin
        port0_mode_high <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_mode_low <= ppmc_pkg::RST_MODE_REG;
      port1_mode_high <= ppmc_pkg::RST_MODE_REG;
    end else if (wr_access) begin
      if (paddr == ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT1_MODE_LOW)) begin
        port1_mode_low <= pwdata[7:0] & ppmc_pkg::PORT1_IMPL_MASK;
      end
      if (paddr == ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT1_MODE_HIGH)) begin
        port1_mode_high <= pwdata[7:0] & ppmc_pkg::PORT1_IMPL_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port2_mode_low_misc <= ppmc_pkg::RST_MODE_REG;
    end else if (wr_access
        && paddr == ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC)) begin
      port2_mode_low_misc <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port2_mode_high <= ppmc_pkg::RST_MODE_REG[1:0];
    end else if (wr_access
        && paddr == ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_HIGH)) begin
      port2_mode_high <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  // input type
  assign port2_schmitt_select = port2_mode_low_misc[ppmc_pkg::BIT_PORT2_SCHMITT];
  assign port1_schmitt_select = port2_mode_low_misc[ppmc_pkg::BIT_PORT1_SCHMITT];
  assign port0_schmitt_select = port2_mode_low_misc[ppmc_pkg::BIT_PORT0_SCHMITT];
  assign clock_out_enable = port2_mode_low_misc[ppmc_pkg::BIT_CLOCK_OUT_EN];
  assign timer1_toggle_out_enable = port2_mode_low_misc[ppmc_pkg::BIT_TIMER1_TOGGLE_EN];
  assign timer0_toggle_out_enable = port2_mode_low_misc[ppmc_pkg::BIT_TIMER0_TOGGLE_EN];

  // ----------------------------------------
  // decoders and toggles
  // ----------------------------------------
  ppmc_mode_decode #(.WIDTH(8)) u_port0_decode (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .mode_low(port0_mode_low),
    .mode_high(port0_mode_high),
    .pin_mode(port0_pin_mode)
  );

  ppmc_mode_decode #(.WIDTH(8)) u_port1_decode (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .mode_low(port1_mode_low),
    .mode_high(port1_mode_high),
    .pin_mode(port1_pin_mode)
  );

  ppmc_mode_decode #(.WIDTH(ppmc_pkg::PORT2_PINS)) u_port2_decode (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .mode_low(port2_mode_low_misc[1:0]),
    .mode_high(port2_mode_high),
    .pin_mode(port2_pin_mode)
  );

  // timer overflows come from same-clock logic, so no synchroniser
  // timer1 to p0.7
  ppmc_toggle u_timer1_toggle (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .enable(port2_mode_low_misc[ppmc_pkg::BIT_TIMER1_TOGGLE_EN]),
    .overflow(timer1_overflow),
    .level(port0_pin7_toggle_level)
  );

  ppmc_toggle u_timer0_toggle (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .enable(port2_mode_low_misc[ppmc_pkg::BIT_TIMER0_TOGGLE_EN]),
    .overflow(timer0_overflow),
    .level(port1_pin2_toggle_level)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup(logic [ppmc_pkg::ADDR_W-1:0] a, logic wr);
    pclken && psel && !penable && pwrite == wr && paddr == a;
  endsequence

  sequence s_access;
    pclken && psel && penable && pready;
  endsequence

  property p_pair;
    pclken ##1 pclken
      |-> port2_pin_mode[3:2]
        == ppmc_pkg::mode_of($past(port2_mode_low_misc[1]), $past(port2_mode_high[1]));
  endproperty
  a_pair: assert property (p_pair) else $error("port2 pin1 mode not from its bit pair");

  property p_schmitt;
    logic d;
    (s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC), 1'b1), d = pwdata[7])
      ##1 s_access |=> port2_schmitt_select == d;
  endproperty
  a_schmitt: assert property (p_schmitt) else $error("port2 input type not written");

  property p_clock_out;
    logic d;
    (s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC), 1'b1), d = pwdata[4])
      ##1 s_access |=> clock_out_enable == d;
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock output select not written");

  property p_s1;
    logic d;
    (s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC), 1'b1),
      d = pwdata[ppmc_pkg::BIT_PORT1_SCHMITT])
      ##1 s_access |=> port1_schmitt_select == d;
  endproperty
  a_s1: assert property (p_s1) else $error("port1 input type not written");

  property p_s0;
    logic d;
    (s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC), 1'b1),
      d = pwdata[ppmc_pkg::BIT_PORT0_SCHMITT])
      ##1 s_access |=> port0_schmitt_select == d;
  endproperty
  a_s0: assert property (p_s0) else $error("port0 input type not written");

  property p_t1_en;
    logic d;
    (s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC), 1'b1),
      d = pwdata[ppmc_pkg::BIT_TIMER1_TOGGLE_EN])
      ##1 s_access |=> timer1_toggle_out_enable == d;
  endproperty
  a_t1_en: assert property (p_t1_en) else $error("p0.7 toggle enable not written");

  property p_t0_en;
    logic d;
    (s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_LOW_MISC), 1'b1),
      d = pwdata[ppmc_pkg::BIT_TIMER0_TOGGLE_EN])
      ##1 s_access |=> timer0_toggle_out_enable == d;
  endproperty
  a_t0_en: assert property (p_t0_en) else $error("p1.2 toggle enable not written");

  // unstored bits must read back as zero, not as whatever was last written
  property p_p1_read;
    s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT1_MODE_HIGH), 1'b0)
      |=> pready && (prdata[7:0] & ~ppmc_pkg::PORT1_IMPL_MASK) == '0 && prdata[31:8] == '0;
  endproperty
  a_p1_read: assert property (p_p1_read) else $error("port1 pin5 bit reads nonzero");

  property p_t1_toggle;
    (pclken && timer1_toggle_out_enable && timer1_overflow)
      |=> port0_pin7_toggle_level != $past(port0_pin7_toggle_level);
  endproperty
  a_t1_toggle: assert property (p_t1_toggle) else $error("p0.7 did not toggle");

  property p_t0_toggle;
    (pclken && timer0_toggle_out_enable && timer0_overflow)
      |=> port1_pin2_toggle_level != $past(port1_pin2_toggle_level);
  endproperty
  a_t0_toggle: assert property (p_t0_toggle) else $error("p1.2 did not toggle");

  property p_p1_unimpl;
    port1_pin_mode[11:10] == ppmc_pkg::ppmc_mode_quasi && !port1_mode_low[5];
  endproperty
  a_p1_unimpl: assert property (p_p1_unimpl) else $error("port1 pin5 mode stored");

  property p_p2_read;
    s_setup(ppmc_pkg::reg_addr(ppmc_pkg::IDX_PORT2_MODE_HIGH), 1'b0)
      |=> pready && prdata[31:2] == '0 && !pslverr;
  endproperty
  a_p2_read: assert property (p_p2_read) else $error("port2 high reads nonzero top bits");

  property p_one_wait;
    (pclken && psel && !penable) |=> pready ##1 (!pready || !pclken);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("apb answer not one access cycle");

endmodule

// *** bench/ppmc_pins_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// pads of the toggle and clock pins
// ----------------------------------------
// each pad has an external pull-up, so a released pad reads high
module ppmc_pins_model (
  input wire logic pclk,
  input wire logic [1:0] p07_mode,
  input wire logic [1:0] p12_mode,
  input wire logic t1_en,
  input wire logic t0_en,
  input wire logic clk_en,
  input wire logic p07_lvl,
  input wire logic p12_lvl,
  output logic p07_pin,
  output logic p12_pin,
  output logic xtal_pin
);
  assign p07_pin = (!t1_en || p07_mode == 2'h2) ? 1'b1 : p07_lvl;
  assign p12_pin = (!t0_en || p12_mode == 2'h2) ? 1'b1 : p12_lvl;
  assign xtal_pin = clk_en ? pclk : 1'b1;
endmodule

// *** bench/ppmc_tb_top.sv ***
`timescale 1ns/1ps
module ppmc_tb_top;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} ppmc_row_type;
  logic pclk, presetn, pclken, psel, penable, pwrite, t0_ovf, t1_ovf, pready, pslverr, rerr;
  logic [ppmc_pkg::ADDR_W-1:0] paddr;
  logic [ppmc_pkg::DATA_W-1:0] pwdata, prdata, rdata;
  logic [15:0] p0_mode, p1_mode;
  logic [3:0] p2_mode;
  logic s2, s1, s0, clk_en, t1_en, t0_en, lvl07, lvl12, pin07, pin12, xtal;
  int err_total, checks_done;
  ppmc_row_type rows [8];

  ppmc_top dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_overflow(t0_ovf), .timer1_overflow(t1_ovf),
    .port0_pin_mode(p0_mode), .port1_pin_mode(p1_mode), .port2_pin_mode(p2_mode),
    .port2_schmitt_select(s2), .port1_schmitt_select(s1), .port0_schmitt_select(s0),
    .clock_out_enable(clk_en), .timer1_toggle_out_enable(t1_en),
    .timer0_toggle_out_enable(t0_en), .port0_pin7_toggle_level(lvl07),
    .port1_pin2_toggle_level(lvl12));

  ppmc_pins_model pads (.pclk(pclk), .p07_mode(p0_mode[15:14]), .p12_mode(p1_mode[5:4]),
    .t1_en(t1_en), .t0_en(t0_en), .clk_en(clk_en), .p07_lvl(lvl07), .p12_lvl(lvl12),
    .p07_pin(pin07), .p12_pin(pin12), .xtal_pin(xtal));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one qualified overflow per cycle, then one cycle for the level to show
  task automatic pulse(input logic on_t1, input int cnt);
    @(posedge pclk);
    t1_ovf <= on_t1;
    t0_ovf <= !on_t1;
    repeat (cnt) @(posedge pclk);
    t1_ovf <= 1'b0;
    t0_ovf <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [15:0] modes(input logic [7:0] m1, input logic [7:0] m2);
    for (int n = 0; n < 8; n++) begin
      modes[2*n +: 2] = {m1[n], m2[n]};
    end
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    pclken = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    t0_ovf = 1'b0;
    t1_ovf = 1'b0;
    presetn = 1'b0;
    err_total = 0;
    checks_done = 0;
    rows = '{'{8'hb1, 8'hff, 8'hff}, '{8'hb2, 8'ha5, 8'ha5}, '{8'hb3, 8'hff, 8'hdf},
      '{8'hb4, 8'hff, 8'hdf}, '{8'hb5, 8'hff, 8'hff}, '{8'hb6, 8'hff, 8'h03},
      '{8'hb1, 8'hcc, 8'hcc}, '{8'hb2, 8'haa, 8'haa}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("modes at reset", 32'h0, {p0_mode, p1_mode});
    check("misc at reset", 32'h0,
      {20'h0, p2_mode, s2, s1, s0, clk_en, t1_en, t0_en, lvl07, lvl12});
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rows[i].idx, 8'h00);
      check("reset read", 32'h0, rdata);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 8'h00);
      check("readback", {24'h0, rows[i].rd}, rdata);
      check("slave error", 32'h0, {31'h0, rerr});
    end
    repeat (2) @(posedge pclk);
    check("port0 modes", {16'h0, modes(8'hcc, 8'haa)}, {16'h0, p0_mode});
    check("port1 modes", {16'h0, modes(8'hdf, 8'hdf)}, {16'h0, p1_mode});
    check("port2 modes", 32'hf, {28'h0, p2_mode});
    $display("test table done");
    apb(1'b1, 8'h00, 8'h5a);
    check("unmapped write error", 32'h1, {31'h0, rerr});
    apb(1'b0, 8'h00, 8'h00);
    check("unmapped read", 32'h1, {31'h0, rerr});
    check("unmapped data", 32'h0, rdata);
    apb(1'b0, 8'hb1, 8'h00);
    check("mapped kept", 32'hcc, rdata);
    $display("test unmapped done");
    for (int k = 2; k < 8; k++) begin
      apb(1'b1, 8'hb5, 8'(1 << k));
      #1;
      check("field outputs", 32'(1 << (k - 2)), {26'h0, s2, s1, s0, clk_en, t1_en, t0_en});
    end
    apb(1'b1, 8'hb5, 8'h10);
    @(negedge pclk);
    check("crystal clock low", 32'h0, {31'h0, xtal});
    #6;
    check("crystal clock high", 32'h1, {31'h0, xtal});
    $display("test fields done");
    apb(1'b1, 8'hb5, 8'h0c);
    pulse(1'b1, 1);
    check("p07 after one", 32'h3, {30'h0, lvl07, pin07});
    pulse(1'b1, 2);
    check("p07 after two more", 32'h2, {30'h0, lvl07, lvl12});
    pulse(1'b0, 1);
    check("p12 after one", 32'h1, {31'h0, pin12});
    pulse(1'b0, 1);
    check("p12 after two", 32'h2, {30'h0, lvl07, pin12});
    apb(1'b1, 8'hb5, 8'h00);
    pulse(1'b1, 1);
    check("p07 disabled holds", 32'h3, {30'h0, lvl07, pin07});
    apb(1'b1, 8'hb5, 8'h0c);
    pclken <= 1'b0;
    pulse(1'b1, 1);
    pclken <= 1'b1;
    check("p07 frozen holds", 32'h1, {31'h0, lvl07});
    $display("test toggle done");
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
endmodule
